// ---- core/flash_status_top.sv ----
// Flash status side: ECC result window, option byte, spare test registers, divider gate.
// Assumes an Avalon-MM master on the bus clock and a command sequencer on the same clock.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "flash_status_params.svh"
module flash_status_top
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Raw ECC fault report from the array.
    input wire logic ecc_single_fault_i,
    input wire logic ecc_double_fault_i,
    input wire logic ecc_fault_pflash_i,
    input wire logic [22:0] ecc_fault_addr_i,
    input wire logic [7:0] ecc_raw_par_i,
    input wire logic [63:0] ecc_raw_data_i,
    // Option byte read port.
    output logic nv_rd_req_o,
    output logic [22:0] nv_rd_addr_o,
    input wire logic nv_rd_ack_i,
    input wire logic [7:0] nv_rd_byte_i,
    input wire logic nv_rd_dfault_i,
    // Command sequencer.
    input wire logic cmd_prog_erase_i,
    input wire logic cmd_done_i,
    output logic cmd_launch_o,
    output logic [6:0] divider_value_o,
    // Interrupt.
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////////////////////////
    logic ack_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_nxt;
    logic [5:0] idx;
    logic wr_en;
    logic rd_take;
    logic [6:0] divider_r;
    logic divloaded_r;
    logic [2:0] sel_r;
    logic command_complete_flag_r;
    logic access_error_flag_r;
    logic launch_r;
    logic launch_req;
    logic pe_blocked;
    logic launch_ok;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_en_r;
    logic [3:0] irq_ev;
    logic [3:0] irq_clr;
    logic [7:0] option;
    logic opt_loaded;
    logic bus_too_slow;

    ecc_capture_if ecc ();

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Helpers.
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Word of the result window for a select value.
    function automatic logic [15:0] win_word(input logic [2:0] sel, input logic [7:0] par,
                                             input logic [22:0] addr, input logic [63:0] data);
        logic [15:0] w;
        w = 16'h0000;
        unique case (sel)
            `SEL_PAR: w = {par, 1'b0, addr[22:16]};
            `SEL_ADDR_LO: w = addr[15:0];
            `SEL_DATA0: w = data[15:0];
            `SEL_DATA1: w = data[31:16];
            `SEL_DATA2: w = data[47:32];
            `SEL_DATA3: w = data[63:48];
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // Word write that carries a one in a given bit.
    function automatic logic wr_bit(input logic en, input logic [5:0] at, input logic [5:0] reg_idx,
                                    input logic [31:0] wd, input int bit_pos);
        return en && (at == reg_idx) && wd[bit_pos];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Submodules.
    ////////////////////////////////////////////////////////////////////////////////////////////
    ecc_fault_capture u_capture
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .single_fault_i(ecc_single_fault_i),
        .double_fault_i(ecc_double_fault_i),
        .fault_pflash_i(ecc_fault_pflash_i),
        .fault_addr_i(ecc_fault_addr_i),
        .raw_par_i(ecc_raw_par_i),
        .raw_data_i(ecc_raw_data_i),
        .ecc(ecc)
    );

    option_loader u_option
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .nv_rd_req_o(nv_rd_req_o),
        .nv_rd_addr_o(nv_rd_addr_o),
        .nv_rd_ack_i(nv_rd_ack_i),
        .nv_rd_byte_i(nv_rd_byte_i),
        .nv_rd_dfault_i(nv_rd_dfault_i),
        .option_o(option),
        .loaded_o(opt_loaded)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the request is accepted.
    ////////////////////////////////////////////////////////////////////////////////////////////
    assign idx = avs_address_i[7:2];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
    assign wr_en = avs_write_i & ack_r & avs_byteenable_i[0];
    assign rd_take = avs_read_i & ~ack_r;
    assign avs_readdata_o = readdata_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            `IDX_CLKDIV: rd_nxt[7:0] = {divloaded_r, divider_r};
            `IDX_ECCIDX: rd_nxt[2:0] = sel_r;
            `IDX_STAT: rd_nxt[7:0] = 8'(({7'h00, command_complete_flag_r} << `STAT_COMMAND_COMPLETE_FLAG_BIT) |
                                         ({7'h00, access_error_flag_r} << `STAT_ACCESS_ERROR_FLAG_BIT));
            `IDX_ECCFLAG: rd_nxt[2:0] = {ecc.rec_double, ecc.dfault_flag, ecc.sfault_flag};
            `IDX_ECCWIN: rd_nxt[15:0] = win_word(sel_r, ecc.par, ecc.addr, ecc.data);
            `IDX_OPT: rd_nxt[7:0] = option;
            `IDX_SPARE_A, `IDX_SPARE_B, `IDX_SPARE_C: rd_nxt = 32'h0000_0000;
            `IDX_IRQ_STAT: rd_nxt[3:0] = irq_stat_r;
            `IDX_IRQ_EN: rd_nxt[3:0] = irq_en_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            readdata_r <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            readdata_r <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Divider and result select.
    ////////////////////////////////////////////////////////////////////////////////////////////
    assign divider_value_o = divider_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            divider_r <= 7'h00;
            divloaded_r <= 1'b0;
        end
        else if (wr_en && idx == `IDX_CLKDIV)
        begin
            divider_r <= avs_writedata_i[6:0];
            divloaded_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sel_r <= 3'h0;
        end
        else if (wr_en && idx == `IDX_ECCIDX)
        begin
            sel_r <= avs_writedata_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Command launch gate and status flags.
    ////////////////////////////////////////////////////////////////////////////////////////////
    assign bus_too_slow = (`BUS_CLK_HZ < `MIN_PE_CLK_HZ);
    assign launch_req = command_complete_flag_r &&
                        wr_bit(wr_en, idx, `IDX_STAT, avs_writedata_i, `STAT_COMMAND_COMPLETE_FLAG_BIT);
    assign pe_blocked = cmd_prog_erase_i & (~divloaded_r | bus_too_slow);
    assign launch_ok = launch_req & ~pe_blocked;
    assign cmd_launch_o = launch_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            command_complete_flag_r <= 1'b1;
            launch_r <= 1'b0;
        end
        else
        begin
            launch_r <= launch_ok;
            if (launch_ok)
            begin
                command_complete_flag_r <= 1'b0;
            end
            else if (cmd_done_i)
            begin
                command_complete_flag_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            access_error_flag_r <= 1'b0;
        end
        else
        begin
            access_error_flag_r <= (access_error_flag_r &
                         ~wr_bit(wr_en, idx, `IDX_STAT, avs_writedata_i, `STAT_ACCESS_ERROR_FLAG_BIT)) |
                        (launch_req & pe_blocked);
        end
    end

    assign ecc.sfault_clr = wr_bit(wr_en, idx, `IDX_ECCFLAG, avs_writedata_i,
                                   `ECCFLAG_SINGLE_BIT);
    assign ecc.dfault_clr = wr_bit(wr_en, idx, `IDX_ECCFLAG, avs_writedata_i,
                                   `ECCFLAG_DOUBLE_BIT);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Interrupts.
    ////////////////////////////////////////////////////////////////////////////////////////////
    assign irq_ev = {cmd_done_i, launch_req & pe_blocked, ecc_double_fault_i, ecc_single_fault_i};
    assign irq_clr = (wr_en && idx == `IDX_IRQ_CLR) ? avs_writedata_i[3:0] : 4'h0;
    assign irq_o = |(irq_stat_r & irq_en_r);

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_stat_r <= 4'h0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_en_r <= 4'h0;
        end
        else if (wr_en && idx == `IDX_IRQ_EN)
        begin
            irq_en_r <= avs_writedata_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_win_read(logic [2:0] s);
        rd_take && idx == `IDX_ECCWIN && sel_r == s;
    endsequence

    sequence s_refused_launch;
        launch_req && cmd_prog_erase_i && !divloaded_r;
    endsequence

    AST_WIN_RO: assert property
        (wr_en && idx == `IDX_ECCWIN && (ecc.sfault_flag || ecc.dfault_flag)
         |=> $stable(ecc.addr) && $stable(ecc.par) && $stable(ecc.data))
        else $error("A window write altered stored fault details.");
    AST_SEL0: assert property
        (s_win_read(`SEL_PAR) |=> avs_readdata_o[7] == 1'b0 &&
         avs_readdata_o[15:8] == $past(ecc.par) && avs_readdata_o[6:0] == $past(ecc.addr[22:16]))
        else $error("Select zero word has the wrong layout.");
    AST_SEL_DATA3: assert property
        (s_win_read(`SEL_DATA3) |=> avs_readdata_o[15:0] == $past(ecc.data[63:48]))
        else $error("Select five did not return data word three.");
    AST_UNUSED: assert property
        ((s_win_read(3'h6) or s_win_read(3'h7)) |=> avs_readdata_o == 32'h0000_0000)
        else $error("Unused select did not read zero.");
    AST_OPT_RO: assert property
        (wr_en && idx == `IDX_OPT && opt_loaded |=> $stable(option))
        else $error("Option register changed on a write.");
    AST_SPARE: assert property
        (rd_take && (idx == `IDX_SPARE_B || idx == `IDX_SPARE_C) ##1 !avs_waitrequest_o
         |-> avs_readdata_o == 32'h0000_0000)
        else $error("Spare test register read nonzero.");
    AST_DIVLD: assert property
        (wr_en && idx == `IDX_CLKDIV |=> divloaded_r ##1 divloaded_r)
        else $error("Divider write did not set the loaded flag.");
    AST_ACCESS_ERROR_FLAG: assert property
        (s_refused_launch |=> access_error_flag_r && command_complete_flag_r && !cmd_launch_o)
        else $error("Command ran without a loaded divider.");
endmodule

// ---- core/flash_status_params.svh ----
// Constants for the flash status side: register indices, field positions, reset values.
// Assumes a 32-bit word bus where the byte address is four times the register index.
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// Register indices.
`define IDX_CLKDIV 6'h02
`define IDX_ECCIDX 6'h03
`define IDX_STAT 6'h06
`define IDX_ECCFLAG 6'h07
`define IDX_ECCWIN 6'h0E
`define IDX_OPT 6'h10
`define IDX_SPARE_A 6'h11
`define IDX_SPARE_B 6'h12
`define IDX_SPARE_C 6'h13
`define IDX_IRQ_STAT 6'h14
`define IDX_IRQ_CLR 6'h15
`define IDX_IRQ_EN 6'h16

// Field positions.
`define STAT_COMMAND_COMPLETE_FLAG_BIT 7
`define STAT_ACCESS_ERROR_FLAG_BIT 5
`define CLKDIV_LOADED_BIT 7
`define ECCFLAG_SINGLE_BIT 0
`define ECCFLAG_DOUBLE_BIT 1
`define ECCFLAG_REC_DOUBLE_BIT 2
`define IRQ_SINGLE_BIT 0
`define IRQ_DOUBLE_BIT 1
`define IRQ_ACCESS_ERROR_FLAG_BIT 2
`define IRQ_DONE_BIT 3

// Result window selects.
`define SEL_PAR 3'h0
`define SEL_ADDR_LO 3'h1
`define SEL_DATA0 3'h2
`define SEL_DATA1 3'h3
`define SEL_DATA2 3'h4
`define SEL_DATA3 3'h5

// Option byte location and values.
`define OPT_NV_ADDR 23'h7F_FF0E
`define OPT_RESET_VALUE 8'h00
`define OPT_DFAULT_VALUE 8'hFF

// Clock figures in hertz.
`define BUS_CLK_HZ 32'h017D_7840
`define MIN_PE_CLK_HZ 32'h000F_4240

`endif

// ---- core/flash_status_pkg.sv ----
// Types shared by the flash status modules.
// Assumes the constants header is included by each user.
package flash_status_pkg;

    typedef enum logic [2:0]
    {
        OPT_REQ = 3'b001,
        OPT_WAIT = 3'b010,
        OPT_DONE = 3'b100
    } opt_state_type;

endpackage

// ---- core/ecc_capture_if.sv ----
// Carrier between the register side and the fault capture unit.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface ecc_capture_if;
    logic sfault_flag;
    logic dfault_flag;
    logic rec_double;
    logic sfault_clr;
    logic dfault_clr;
    logic [7:0] par;
    logic [22:0] addr;
    logic [63:0] data;

    modport capt
    (
        input sfault_clr, dfault_clr,
        output sfault_flag, dfault_flag, rec_double, par, addr, data
    );
    modport regs
    (
        output sfault_clr, dfault_clr,
        input sfault_flag, dfault_flag, rec_double, par, addr, data
    );
endinterface

// ---- core/ecc_fault_capture.sv ----
// Captures raw details of the first ECC fault and holds them until the flags clear.
// Assumes fault strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "flash_status_params.svh"
module ecc_fault_capture
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Raw fault report.
    input wire logic single_fault_i,
    input wire logic double_fault_i,
    input wire logic fault_pflash_i,
    input wire logic [22:0] fault_addr_i,
    input wire logic [7:0] raw_par_i,
    input wire logic [63:0] raw_data_i,
    // Register side.
    ecc_capture_if.capt ecc
);
    logic armed;
    logic capture;

    assign armed = ~((ecc.sfault_flag & ~ecc.sfault_clr) |
                     (ecc.dfault_flag & ~ecc.dfault_clr));
    assign capture = armed & (single_fault_i | double_fault_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ecc.sfault_flag <= 1'b0;
            ecc.dfault_flag <= 1'b0;
        end
        else
        begin
            ecc.sfault_flag <= (ecc.sfault_flag & ~ecc.sfault_clr) | single_fault_i;
            ecc.dfault_flag <= (ecc.dfault_flag & ~ecc.dfault_clr) | double_fault_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ecc.rec_double <= 1'b0;
            ecc.par <= 8'h00;
            ecc.addr <= 23'h00_0000;
            ecc.data <= 64'h0000_0000_0000_0000;
        end
        else if (capture)
        begin
            ecc.rec_double <= double_fault_i;
            ecc.addr <= fault_addr_i;
            ecc.par <= fault_pflash_i ? raw_par_i : {2'b00, raw_par_i[5:0]};
            ecc.data <= fault_pflash_i ? raw_data_i : {48'h0000_0000_0000, raw_data_i[15:0]};
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_HOLD: assert property (!armed |=> $stable(ecc.addr) && $stable(ecc.data))
        else $error("Stored fault details changed while capture was locked.");
    AST_PRIO: assert property
        (armed && single_fault_i && double_fault_i |=> ecc.rec_double)
        else $error("Simultaneous faults did not record the double fault.");
    AST_DPAR: assert property (capture && !fault_pflash_i |=> ecc.par[7:6] == 2'b00)
        else $error("Data-array check bits 7:6 not zero.");
    AST_RAW: assert property (capture && fault_pflash_i |=> ecc.data == $past(raw_data_i))
        else $error("Captured data differs from raw array data.");
endmodule

// ---- core/option_loader.sv ----
// Loads the option byte from the nonvolatile configuration field after reset.
// Assumes the array answers a read request with an acknowledge pulse.
`timescale 1ns/1ps
`include "flash_status_params.svh"
module option_loader
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Array read port.
    output logic nv_rd_req_o,
    output logic [22:0] nv_rd_addr_o,
    input wire logic nv_rd_ack_i,
    input wire logic [7:0] nv_rd_byte_i,
    input wire logic nv_rd_dfault_i,
    // Result.
    output logic [7:0] option_o,
    output logic loaded_o
);
    flash_status_pkg::opt_state_type state_r;

    assign nv_rd_req_o = (state_r == flash_status_pkg::OPT_REQ) ||
                         (state_r == flash_status_pkg::OPT_WAIT);
    assign nv_rd_addr_o = `OPT_NV_ADDR;
    assign loaded_o = (state_r == flash_status_pkg::OPT_DONE);

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_r <= flash_status_pkg::OPT_REQ;
        end
        else
        begin
            unique case (state_r)
                flash_status_pkg::OPT_REQ: state_r <= flash_status_pkg::OPT_WAIT;
                flash_status_pkg::OPT_WAIT:
                    if (nv_rd_ack_i)
                    begin
                        state_r <= flash_status_pkg::OPT_DONE;
                    end
                flash_status_pkg::OPT_DONE: state_r <= flash_status_pkg::OPT_DONE;
                default: state_r <= flash_status_pkg::OPT_REQ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            option_o <= `OPT_RESET_VALUE;
        end
        else if (state_r == flash_status_pkg::OPT_WAIT && nv_rd_ack_i)
        begin
            option_o <= nv_rd_dfault_i ? `OPT_DFAULT_VALUE : nv_rd_byte_i;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_OPT_DFAULT: assert property
        (state_r == flash_status_pkg::OPT_WAIT && nv_rd_ack_i && nv_rd_dfault_i
         |=> option_o == `OPT_DFAULT_VALUE && loaded_o)
        else $error("Option byte not all ones after a double fault.");
endmodule

// ---- tb/flash_status_top_tb_top.sv ----
// Self-checking bench for the flash status side.
// Assumes the constants header is on the include path and one 25 MHz bus clock.
`timescale 1ns/1ps
`include "flash_status_params.svh"
module flash_status_top_tb_top;
////////////////////////////////////////////////////////////////////////////////
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic ecc_single_fault_i = 1'b0;
    logic ecc_double_fault_i = 1'b0;
    logic ecc_fault_pflash_i = 1'b0;
    logic [22:0] ecc_fault_addr_i = 23'h00_0000;
    logic [7:0] ecc_raw_par_i = 8'h00;
    logic [63:0] ecc_raw_data_i = 64'h0000_0000_0000_0000;
    logic nv_rd_req_o;
    logic [22:0] nv_rd_addr_o;
    logic nv_rd_ack_i = 1'b0;
    logic [7:0] nv_rd_byte_i = 8'h00;
    logic nv_rd_dfault_i = 1'b0;
    logic cmd_prog_erase_i = 1'b0;
    logic cmd_done_i = 1'b0;
    logic cmd_launch_o;
    logic [6:0] divider_value_o;
    logic irq_o;
    int fails = 0;
    int checked = 0;
    int launches = 0;
    logic [31:0] rd;

    flash_status_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .ecc_single_fault_i(ecc_single_fault_i), .ecc_double_fault_i(ecc_double_fault_i),
        .ecc_fault_pflash_i(ecc_fault_pflash_i), .ecc_fault_addr_i(ecc_fault_addr_i),
        .ecc_raw_par_i(ecc_raw_par_i), .ecc_raw_data_i(ecc_raw_data_i),
        .nv_rd_req_o(nv_rd_req_o), .nv_rd_addr_o(nv_rd_addr_o), .nv_rd_ack_i(nv_rd_ack_i),
        .nv_rd_byte_i(nv_rd_byte_i), .nv_rd_dfault_i(nv_rd_dfault_i),
        .cmd_prog_erase_i(cmd_prog_erase_i), .cmd_done_i(cmd_done_i),
        .cmd_launch_o(cmd_launch_o), .divider_value_o(divider_value_o), .irq_o(irq_o));
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i)
    begin
        if (cmd_launch_o === 1'b1) launches++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One Avalon access; waits for waitrequest low with no bound of its own, then checks a count of two.
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= wd;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0);
        chk(n, 2, "bus latency");
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic win(input logic [2:0] sel, input logic [15:0] exp, input string what);
        bus(1'b1, `IDX_ECCIDX, {29'h0, sel});
        bus(1'b0, `IDX_ECCWIN, 32'h0000_0000);
        chk(rd, {16'h0000, exp}, what);
    endtask

    task automatic fault(input logic s, input logic d, input logic pf, input logic [22:0] a,
                         input logic [7:0] p, input logic [63:0] dat);
        @(posedge clk_sys_i);
        ecc_single_fault_i <= s;
        ecc_double_fault_i <= d;
        ecc_fault_pflash_i <= pf;
        ecc_fault_addr_i <= a;
        ecc_raw_par_i <= p;
        ecc_raw_data_i <= dat;
        @(posedge clk_sys_i);
        ecc_single_fault_i <= 1'b0;
        ecc_double_fault_i <= 1'b0;
    endtask
////////////////////////////////////////////////////////////////////////////////
    // Reset, then answer the option read with a byte or a double fault.
    task automatic do_reset(input logic df, input logic [7:0] b);
        int n;
        n = 0;
        srst_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (nv_rd_req_o !== 1'b1 && n < 50);
        chk(nv_rd_addr_o, 23'h7F_FF0E, "option addr");
        nv_rd_ack_i <= 1'b1;
        nv_rd_byte_i <= b;
        nv_rd_dfault_i <= df;
        @(posedge clk_sys_i);
        nv_rd_ack_i <= 1'b0;
        nv_rd_dfault_i <= 1'b0;
        bus(1'b0, `IDX_OPT, 32'h0000_0000);
        chk(rd, df ? 32'h0000_00FF : {24'h0, b}, "option value");
    endtask

    task automatic test_readonly();
        bus(1'b1, `IDX_OPT, 32'h0000_0011);
        bus(1'b0, `IDX_OPT, 32'h0000_0000);
        chk(rd, 32'h0000_005C, "option write");
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, 6'h11 + i[5:0], 32'h0000_00FF);
            bus(1'b0, 6'h11 + i[5:0], 32'h0000_0000);
            chk(rd, 32'h0000_0000, "spare test reg");
        end
        bus(1'b0, 6'h3F, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
    endtask

    task automatic test_gate();
        cmd_prog_erase_i <= 1'b1;
        bus(1'b0, `IDX_CLKDIV, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "divider after reset");
        bus(1'b1, `IDX_STAT, 32'h0000_0080);
        repeat (3) @(posedge clk_sys_i);
        chk(launches, 0, "refused launch");
        bus(1'b0, `IDX_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_00A0, "access error");
        bus(1'b1, `IDX_CLKDIV, 32'h0000_0005);
        bus(1'b0, `IDX_CLKDIV, 32'h0000_0000);
        chk(rd, 32'h0000_0085, "divider loaded");
        chk(divider_value_o, 7'h05, "divider out");
        bus(1'b1, `IDX_STAT, 32'h0000_0020);
        bus(1'b1, `IDX_STAT, 32'h0000_0080);
        repeat (3) @(posedge clk_sys_i);
        chk(launches, 1, "launch pulse");
        bus(1'b0, `IDX_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "busy status");
        @(posedge clk_sys_i);
        cmd_done_i <= 1'b1;
        @(posedge clk_sys_i);
        cmd_done_i <= 1'b0;
        bus(1'b0, `IDX_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0080, "done status");
    endtask

    task automatic test_ecc();
        bus(1'b1, `IDX_IRQ_EN, 32'h0000_0001);
        fault(1'b1, 1'b0, 1'b1, 23'h5A_1234, 8'hA5, 64'h4444_3333_2222_1111);
        @(negedge clk_sys_i);
        chk(irq_o, 1'b1, "irq raised");
        fault(1'b1, 1'b0, 1'b1, 23'h01_7777, 8'h00, 64'h0000_0000_0000_0000);
        win(3'h0, 16'hA55A, "par and high addr");
        win(3'h1, 16'h1234, "low addr");
        for (int k = 0; k < 4; k++)
        begin
            win(3'h2 + k[2:0], 16'(16'h1111 * (k + 1)), "data word");
        end
        bus(1'b1, `IDX_ECCWIN, 32'h0000_FFFF);
        win(3'h6, 16'h0000, "select 6");
        win(3'h7, 16'h0000, "select 7");
        win(3'h1, 16'h1234, "window write");
        bus(1'b1, `IDX_IRQ_EN, 32'h0000_0000);
        @(negedge clk_sys_i);
        chk(irq_o, 1'b0, "irq masked");
        bus(1'b1, `IDX_IRQ_CLR, 32'h0000_0001);
        bus(1'b0, `IDX_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_000C, "irq cleared");
        bus(1'b1, `IDX_ECCFLAG, 32'h0000_0003);
        fault(1'b1, 1'b1, 1'b0, 23'h10_0ABC, 8'hFF, 64'h0000_0000_0000_BEEF);
        bus(1'b0, `IDX_ECCFLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0007, "double recorded");
        win(3'h0, 16'h3F10, "data par");
        win(3'h1, 16'h0ABC, "data low addr");
        win(3'h2, 16'hBEEF, "data word");
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        do_reset(1'b0, 8'h5C);
        test_readonly();
        test_gate();
        test_ecc();
        do_reset(1'b1, 8'h12);
        bus(1'b0, `IDX_CLKDIV, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "divider after second reset");
        give_verdict();
    end
endmodule
